// [hdl/rbsl_regs.vh]
// constants of the reset and boot strap latch
`ifndef RBSL_REGS_VH
`define RBSL_REGS_VH
`define RBSL_CLK_HZ          100000000
`define RBSL_RELEASE_MS      200
`define RBSL_RELEASE_CYCLES  (`RBSL_CLK_HZ / 1000 * `RBSL_RELEASE_MS)
`define RBSL_CNT_W           25
`define RBSL_RAILS           3
`define RBSL_PLL_RST         5'h08
`define RBSL_PLL_RATIO_RST   2'h3
`define RBSL_BUSDIV_LOW      4'h4
`define RBSL_BUSDIV_HIGH     4'h8
`define RBSL_MULT_LOW        5'h10
`define RBSL_MULT_HIGH       5'h0c
`define RBSL_VEC_LOW         32'h0000_0100
`define RBSL_VEC_HIGH        32'hfff0_0100
`define RBSL_WAIT_LOW        6'h04
`define RBSL_WAIT_HIGH       6'h30
`define RBSL_ADDR_BITS       5'h19
`define RBSL_WIDTH_LOW       6'h10
`define RBSL_WIDTH_HIGH      6'h20
// strap word field positions
`define RBSL_F_BUSDIV        0
`define RBSL_F_MULT          1
`define RBSL_F_VCO           2
`define RBSL_F_GFX           3
`define RBSL_F_VEC           4
`define RBSL_F_WAIT          5
`define RBSL_F_SWAP          6
`define RBSL_F_WIDTH         7
`define RBSL_F_MUX           8
`define RBSL_F_FLASH         9
`define RBSL_STRAP_W         10
`define RBSL_STRAP_RST       10'h0_1b0
`endif

// [hdl/rbsl_sync.v]
// two-flop synchroniser for one level
module rbsl_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,
    input  wire reset,
    input  wire d,
    output wire q
);
    reg s1_r;
    reg s2_r;
    always @(posedge clk) begin
        if (reset) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule

// [hdl/rbsl_release_timer.v]
// release delay counter, restarts while held
`include "rbsl_regs.vh"
module rbsl_release_timer #(
    parameter RELEASE_CYCLES = `RBSL_RELEASE_CYCLES
) (
    input  wire clk,
    input  wire reset,
    input  wire hold,
    output reg  done
);
    localparam integer           LAST_I = RELEASE_CYCLES - 1;
    // count fits the counter width for the full 200 ms span
    localparam [`RBSL_CNT_W-1:0] LAST = LAST_I[`RBSL_CNT_W-1:0];
    reg [`RBSL_CNT_W-1:0] cnt_r;
    always @(posedge clk) begin
        if (reset || hold) begin
            cnt_r <= {`RBSL_CNT_W{1'b0}};
            done  <= 1'b0;
        end else if (!done) begin
            if (cnt_r == LAST)
                done <= 1'b1;
            else
                cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

// [hdl/rbsl_top.v]
// power-on reset sequencer and boot strap latch
// Function
// - reset asserts while any rail low
// - release 200 ms after rails good
// - debug reset is OR of sources
// - manual reset acts like supply fault
// - capture straps at reset rising edge
// - pll straps default give ratio 1:3
// - bus divider four low, eight high
// - multiplier sixteen low, twelve high
// - vco equals or doubles system pll
// - graphics boot when strap high
// - boot vector chosen by strap
// - boot wait 4 or 48 clocks
// - byte lane swap when strap high
// - boot width 16 or 32 bits
// - muxed boot bus when strap high
// - large flash boot when strap high
`include "rbsl_regs.vh"
module rbsl_top #(
    parameter RELEASE_CYCLES = `RBSL_RELEASE_CYCLES
) (
    input  wire                     clk,
    input  wire                     reset,
    input  wire [`RBSL_RAILS-1:0]   rail_good,
    input  wire                     manual_reset_n,
    input  wire                     debug_port_reset_n,
    input  wire [4:0]               core_pll_strap,
    input  wire [`RBSL_STRAP_W-1:0] boot_strap,
    output reg                      power_on_reset_n,
    output reg                      debug_controller_reset_n,
    output reg  [4:0]               core_pll_pick,
    output reg  [1:0]               core_ratio,
    output reg  [3:0]               bus_divider,
    output reg  [4:0]               system_multiplier,
    output reg                      system_multiplier_pick,
    output reg                      vco_doubler_pick,
    output reg                      graphics_boot_pick,
    output reg  [31:0]              boot_vector,
    output reg  [5:0]               boot_wait_states,
    output reg                      boot_lane_swap,
    output reg  [5:0]               boot_data_width,
    output reg  [4:0]               boot_addr_bits,
    output reg                      boot_bus_muxed,
    output reg                      large_flash_boot
);
    wire [`RBSL_RAILS-1:0] rail_s;
    wire                   man_s;
    wire                   dbg_s;
    wire [4:0]             pll_s;
    wire [`RBSL_STRAP_W-1:0] strap_s;
    wire                   timer_done;
    wire                   fault;
    reg                    por_n_d_r;

    // every input except clk and reset is synchronised; straps too, as they ride on shared lines
    genvar i;
    generate
        for (i = 0; i < `RBSL_RAILS; i = i + 1) begin : g_rail
            rbsl_sync #(.RST_VAL(1'b0)) u_s (
                .clk   (clk),
                .reset (reset),
                .d     (rail_good[i]),
                .q     (rail_s[i])
            );
        end
        for (i = 0; i < 5; i = i + 1) begin : g_pll
            rbsl_sync #(.RST_VAL(1'b0)) u_s (
                .clk   (clk),
                .reset (reset),
                .d     (core_pll_strap[i]),
                .q     (pll_s[i])
            );
        end
        for (i = 0; i < `RBSL_STRAP_W; i = i + 1) begin : g_strap
            rbsl_sync #(.RST_VAL(1'b0)) u_s (
                .clk   (clk),
                .reset (reset),
                .d     (boot_strap[i]),
                .q     (strap_s[i])
            );
        end
    endgenerate

    rbsl_sync #(.RST_VAL(1'b0)) u_man (
        .clk   (clk),
        .reset (reset),
        .d     (manual_reset_n),
        .q     (man_s)
    );
    rbsl_sync #(.RST_VAL(1'b0)) u_dbg (
        .clk   (clk),
        .reset (reset),
        .d     (debug_port_reset_n),
        .q     (dbg_s)
    );

    // any bad rail or a held manual button counts as fault
    assign fault = ~(&rail_s) | ~man_s;

    rbsl_release_timer #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_tmr (
        .clk   (clk),
        .reset (reset),
        .hold  (fault),
        .done  (timer_done)
    );

    // release only on a clock edge after the full count; fault drops it on the next clock edge
    always @(posedge clk) begin
        if (reset) begin
            power_on_reset_n         <= 1'b0;
            debug_controller_reset_n <= 1'b0;
            por_n_d_r                <= 1'b0;
        end else begin
            power_on_reset_n <= timer_done & ~fault;
            por_n_d_r        <= power_on_reset_n;
            debug_controller_reset_n <= timer_done & ~fault & dbg_s;
        end
    end

    // straps latched once per reset release; outside parties must not drive
    // the strap lines while reset is low, nothing here can guard against it
    always @(posedge clk) begin
        if (reset) begin
            core_pll_pick          <= `RBSL_PLL_RST;
            core_ratio             <= `RBSL_PLL_RATIO_RST;
            bus_divider            <= `RBSL_BUSDIV_LOW;
            system_multiplier      <= `RBSL_MULT_LOW;
            system_multiplier_pick <= 1'b0;
            vco_doubler_pick       <= 1'b0;
            graphics_boot_pick     <= 1'b0;
            boot_vector            <= `RBSL_VEC_HIGH;
            boot_wait_states       <= `RBSL_WAIT_HIGH;
            boot_lane_swap         <= 1'b0;
            boot_data_width        <= `RBSL_WIDTH_LOW;
            boot_addr_bits         <= `RBSL_ADDR_BITS;
            boot_bus_muxed         <= 1'b1;
            large_flash_boot       <= 1'b0;
        end else if (power_on_reset_n && !por_n_d_r) begin
            core_pll_pick <= pll_s;
            // only the default pattern has a known ratio here
            if (pll_s == `RBSL_PLL_RST)
                core_ratio <= `RBSL_PLL_RATIO_RST;
            else
                core_ratio <= 2'h0;
            bus_divider <= strap_s[`RBSL_F_BUSDIV] ? `RBSL_BUSDIV_HIGH
                                                   : `RBSL_BUSDIV_LOW;
            system_multiplier <= strap_s[`RBSL_F_MULT] ? `RBSL_MULT_HIGH
                                                       : `RBSL_MULT_LOW;
            system_multiplier_pick <= strap_s[`RBSL_F_MULT];
            vco_doubler_pick   <= strap_s[`RBSL_F_VCO];
            graphics_boot_pick <= strap_s[`RBSL_F_GFX];
            boot_vector <= strap_s[`RBSL_F_VEC] ? `RBSL_VEC_HIGH
                                                : `RBSL_VEC_LOW;
            boot_wait_states <= strap_s[`RBSL_F_WAIT] ? `RBSL_WAIT_HIGH
                                                      : `RBSL_WAIT_LOW;
            boot_lane_swap <= strap_s[`RBSL_F_SWAP];
            boot_data_width <= strap_s[`RBSL_F_WIDTH] ? `RBSL_WIDTH_HIGH
                                                      : `RBSL_WIDTH_LOW;
            boot_addr_bits   <= `RBSL_ADDR_BITS;
            boot_bus_muxed   <= strap_s[`RBSL_F_MUX];
            large_flash_boot <= strap_s[`RBSL_F_FLASH];
        end
    end
endmodule

// [bench/rbsl_strap_net.sv]
// strap pull network with an outside driver sharing the lines
module rbsl_strap_net (
    input  wire logic        power_on_reset_n,
    input  wire logic [14:0] pull,
    input  wire logic [14:0] ext_val,
    input  wire logic        ext_en,
    output logic      [4:0]  core_pll_strap,
    output logic      [9:0]  boot_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside logic keeps off the lines until reset is released
    assign {core_pll_strap, boot_strap} =
        (ext_en && power_on_reset_n) ? ext_val : pull;
endmodule

// [bench/rbsl_top_properties.sv]
// assertions on the reset sequencer and strap latch ports
`include "rbsl_regs.vh"
module rbsl_props #(
    parameter int RELEASE_CYCLES = 20
) (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic [`RBSL_RAILS-1:0] rail_good,
    input wire logic                   manual_reset_n,
    input wire logic                   debug_port_reset_n,
    input wire logic                   power_on_reset_n,
    input wire logic                   debug_controller_reset_n,
    input wire logic [4:0]             core_pll_pick,
    input wire logic [1:0]             core_ratio,
    input wire logic [4:0]             system_multiplier,
    input wire logic                   system_multiplier_pick,
    input wire logic [31:0]            boot_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] good_cnt_r;
    wire         fault = !(&rail_good) || !manual_reset_n;
    // saturates so a long quiet run cannot wrap
    always @(posedge clk)
        if (reset || fault) good_cnt_r <= 0;
        else if (good_cnt_r < 1000) good_cnt_r <= good_cnt_r + 1;
    sequence s_rail_low; !(&rail_good) [*5]; endsequence
    sequence s_manual_low; !manual_reset_n [*5]; endsequence
    a_rail_fault_reset: assert property (s_rail_low |=> !power_on_reset_n)
        else $error("reset not asserted on rail fault");
    a_manual_fault_reset: assert property (s_manual_low |=> !power_on_reset_n)
        else $error("reset not asserted on manual reset");
    a_debug_port_or: assert property (!debug_port_reset_n [*5] |=> !debug_controller_reset_n)
        else $error("debug reset ignores debug input");
    a_debug_por_or: assert property (!power_on_reset_n |-> !debug_controller_reset_n)
        else $error("debug reset high while system reset low");
    a_release_not_early: assert property ($rose(power_on_reset_n) |-> good_cnt_r >= RELEASE_CYCLES)
        else $error("reset released too early");
    a_release_not_late: assert property (good_cnt_r == RELEASE_CYCLES + 6 |-> power_on_reset_n)
        else $error("reset released too late");
    a_straps_only_release: assert property ($changed(boot_vector) |-> $past(power_on_reset_n) && !$past(power_on_reset_n, 2))
        else $error("strap output changed away from release");
    a_mult_decode: assert property (system_multiplier == (system_multiplier_pick ? 5'h0c : 5'h10))
        else $error("multiplier does not match its strap");
    a_ratio_decode: assert property (core_ratio == ((core_pll_pick == 5'h08) ? 2'h3 : 2'h0))
        else $error("core ratio does not match pll strap");
endmodule
bind rbsl_top rbsl_props #(.RELEASE_CYCLES(RELEASE_CYCLES)) rbsl_props_i (
    .clk(clk), .reset(reset), .rail_good(rail_good),
    .manual_reset_n(manual_reset_n), .debug_port_reset_n(debug_port_reset_n),
    .power_on_reset_n(power_on_reset_n), .core_ratio(core_ratio),
    .debug_controller_reset_n(debug_controller_reset_n),
    .core_pll_pick(core_pll_pick), .system_multiplier(system_multiplier),
    .system_multiplier_pick(system_multiplier_pick), .boot_vector(boot_vector));

// [bench/tb.sv]
// self-checking bench for the reset sequencer and strap latch
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 20;
    logic clk = 0, reset = 1, manual_reset_n = 1, debug_port_reset_n = 1;
    logic [2:0] rail_good = 3'h7;
    logic [14:0] pull = {5'h08, 10'h130}, ext_val = 15'h0, s;
    logic ext_en = 0;
    int n_tests = 0, n_mismatch = 0;
    wire [4:0] core_pll_strap, core_pll_pick, system_multiplier, boot_addr_bits;
    wire [9:0] boot_strap;
    wire [1:0] core_ratio;
    wire [3:0] bus_divider;
    wire [31:0] boot_vector;
    wire [5:0] boot_wait_states, boot_data_width;
    wire power_on_reset_n, debug_controller_reset_n, system_multiplier_pick;
    wire vco_doubler_pick, graphics_boot_pick, boot_lane_swap, boot_bus_muxed;
    wire large_flash_boot;
    wire [70:0] outs = {core_pll_pick, core_ratio, bus_divider,
        system_multiplier, system_multiplier_pick, vco_doubler_pick,
        graphics_boot_pick, boot_vector, boot_wait_states, boot_lane_swap,
        boot_data_width, boot_addr_bits, boot_bus_muxed, large_flash_boot};
    rbsl_top #(.RELEASE_CYCLES(RC)) rbsl_top_i (.*);
    rbsl_strap_net rbsl_strap_net_i (.*);
    always #5 clk = ~clk;
    function automatic logic [70:0] exp_of(logic [14:0] v);
        return {v[14:10], (v[14:10] == 5'h08) ? 2'h3 : 2'h0,
            v[0] ? 4'h8 : 4'h4, v[1] ? 5'h0c : 5'h10, v[1], v[2], v[3],
            v[4] ? 32'hfff0_0100 : 32'h0000_0100, v[5] ? 6'h30 : 6'h04,
            v[6], v[7] ? 6'h20 : 6'h10, 5'h19, v[8], v[9]};
    endfunction
    task automatic check(string what, logic [70:0] e, logic [70:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic release_check(logic [14:0] v);
        int n = 0;
        @(negedge clk);
        while (power_on_reset_n !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("release", 71'(1), 71'(n >= RC && n <= RC + 6));
        repeat (3) @(negedge clk);
        check("straps", exp_of(v), outs);
    endtask
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        summarize;
    end
    initial begin
        void'($urandom(18));
        repeat (6) @(posedge clk);
        reset <= 0;
        @(negedge clk);
        check("defaults", exp_of(pull), outs);
        check("por", 71'(0), 71'(power_on_reset_n));
        release_check(pull);
        for (int i = 0; i < 6; i++) begin
            s = 15'($urandom);
            @(posedge clk);
            pull <= s;
            if (i[0]) rail_good <= ~(3'h1 << (i % 3));
            else manual_reset_n <= 0;
            repeat (6) @(posedge clk);
            @(negedge clk);
            check("fault", 71'(0), 71'({power_on_reset_n, debug_controller_reset_n}));
            @(posedge clk);
            if (i == 2) begin
                manual_reset_n <= 1;
                repeat (RC / 2) @(posedge clk);
                manual_reset_n <= 0;
                @(posedge clk);
            end
            rail_good <= 3'h7;
            manual_reset_n <= 1;
            release_check(s);
        end
        @(posedge clk);
        debug_port_reset_n <= 0;
        repeat (6) @(negedge clk);
        check("debug", 71'(2), 71'({power_on_reset_n, debug_controller_reset_n}));
        @(posedge clk);
        debug_port_reset_n <= 1;
        ext_val <= ~s;
        ext_en <= 1;
        repeat (6) @(negedge clk);
        check("debug_off", 71'(3), 71'({power_on_reset_n, debug_controller_reset_n}));
        check("hold", exp_of(s), outs);
        @(posedge clk);
        reset <= 1;
        repeat (6) @(posedge clk);
        reset <= 0;
        release_check(s);
        summarize;
    end
endmodule
